// file: shared/timer_ctl_pkg.sv
// Package: register map, field layout and types for the timer control block
package timer_ctl_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE_A = 8'h04;
  localparam logic [7:0] OFS_MODE_B = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_COUNT_A = 8'h10;
  localparam logic [7:0] OFS_COUNT_B = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_RTC = 8'h20;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int B_EDGE_B_HI = 11;
  localparam int B_EDGE_B_LO = 10;
  localparam int B_FREEZE_B = 9;
  localparam int B_RUN_B = 8;
  localparam int B_RSVD7 = 7;
  localparam int B_PWM_INV_A = 6;
  localparam int B_ADC_TRIG_A = 5;
  localparam int B_RTC_EN = 4;
  localparam int B_EDGE_A_HI = 3;
  localparam int B_EDGE_A_LO = 2;
  localparam int B_FREEZE_A = 1;
  localparam int B_RUN_A = 0;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [11:0] CONTROL_RESET = 12'h000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] RTC_RESET = 32'h0000_0000;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RSVD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] MODE_RSVD = 2'h0;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] edge_b;
    logic freeze_b;
    logic run_b;
    logic rsvd7;
    logic pwm_inv_a;
    logic adc_trig_a;
    logic rtc_en;
    logic [1:0] edge_a;
    logic freeze_a;
    logic run_a;
  } control_t;

  typedef struct packed {
    logic run;
    logic freeze;
    logic [1:0] mode;
    logic [1:0] edge_sel;
  } half_cfg_t;

  typedef struct packed {
    logic [15:0] count;
    logic active;
    logic timeout;
    logic capture;
  } half_state_t;

endpackage

// file: verilog/edge_detect.sv
// Capture edge detector with two-flop pin synchroniser
`timescale 1ns/10ps
`default_nettype none
module edge_detect
  import timer_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  output logic hit_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic rise;
  logic fall;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

  always_comb
  begin
    unique case (edge_sel_i)
      EDGE_RISE: hit_o = rise;
      EDGE_FALL: hit_o = fall;
      EDGE_BOTH: hit_o = rise | fall;
      default: hit_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// file: verilog/timer_half.sv
// One 16-bit timer half: one-shot, periodic and edge-count capture
`timescale 1ns/10ps
`default_nettype none
module timer_half
  import timer_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire half_cfg_t cfg_i,
  input wire logic halted_i,
  input wire logic [15:0] load_i,
  input wire logic edge_hit_i,
  output half_state_t state_o
);
  logic [15:0] count_q;
  logic active_q;
  logic timeout_q;
  logic capture_q;
  logic step;

  // Frozen only while halted by the debugger and freeze is set
  assign step = cfg_i.run & ~(halted_i & cfg_i.freeze);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q <= COUNT_RESET;
      active_q <= 1'b0;
      timeout_q <= 1'b0;
      capture_q <= 1'b0;
    end
    else
    begin
      timeout_q <= 1'b0;
      capture_q <= 1'b0;
      if (!cfg_i.run)
      begin
        count_q <= load_i;
        active_q <= 1'b0;
      end
      else if (step)
      begin
        unique case (cfg_i.mode)
          MODE_ONESHOT:
          begin
            active_q <= count_q != 16'h0000;
            if (count_q != 16'h0000)
            begin
              count_q <= count_q - 16'h0001;
              timeout_q <= count_q == 16'h0001;
            end
          end
          MODE_PERIODIC:
          begin
            active_q <= 1'b1;
            if (count_q == 16'h0000)
            begin
              count_q <= load_i;
              timeout_q <= 1'b1;
            end
            else
            begin
              count_q <= count_q - 16'h0001;
            end
          end
          MODE_CAPTURE:
          begin
            active_q <= 1'b1;
            if (edge_hit_i)
            begin
              count_q <= count_q - 16'h0001;
              capture_q <= 1'b1;
            end
          end
          default: active_q <= 1'b0;
        endcase
      end
    end
  end

  assign state_o = '{count: count_q, active: active_q, timeout: timeout_q, capture: capture_q};
endmodule
`default_nettype wire

// file: verilog/timer_ctl.sv
// Timer module with control register, two 16-bit halves and RTC counter
`timescale 1ns/10ps
`default_nettype none
module timer_ctl
  import timer_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic err_o,
  input wire logic debug_halt_i,
  input wire logic capture_a_i,
  input wire logic capture_b_i,
  output logic pwm_a_o,
  output logic adc_trigger_a_o,
  output logic [11:0] control_o
);
  import timer_ctl_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  control_t ctl_q;
  logic [1:0] mode_a_q;
  logic [1:0] mode_b_q;
  logic [15:0] load_a_q;
  logic [15:0] load_b_q;
  logic [31:0] rtc_q;
  logic halt_meta_q;
  logic halt_q;
  logic pwm_raw_q;
  half_state_t st_a;
  half_state_t st_b;
  logic hit_a;
  logic hit_b;
  logic req;
  logic wr;
  logic hit_map;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr = req & we_i;

  always_comb
  begin
    unique case (adr_i)
      OFS_MODE_A, OFS_MODE_B, OFS_CONTROL, OFS_COUNT_A, OFS_COUNT_B, OFS_STATUS, OFS_RTC:
        hit_map = 1'b1;
      default: hit_map = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end
    else
    begin
      ack_o <= req & hit_map;
      err_o <= req & ~hit_map;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (req)
    begin
      unique case (adr_i)
        OFS_MODE_A: dat_o <= {30'h0, mode_a_q};
        OFS_MODE_B: dat_o <= {30'h0, mode_b_q};
        OFS_CONTROL: dat_o <= {20'h0, ctl_q};
        OFS_COUNT_A: dat_o <= {16'h0, st_a.count};
        OFS_COUNT_B: dat_o <= {16'h0, st_b.count};
        OFS_STATUS: dat_o <= {28'h0, st_b.active, st_a.active, halt_q, rtc_q != RTC_RESET};
        OFS_RTC: dat_o <= rtc_q;
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctl_q <= CONTROL_RESET;
    end
    else if (wr && adr_i == OFS_CONTROL)
    begin
      ctl_q <= 12'(merge({20'h0, ctl_q}, dat_i, sel_i));
      ctl_q.rsvd7 <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_a_q <= MODE_RESET;
      mode_b_q <= MODE_RESET;
      load_a_q <= COUNT_RESET;
      load_b_q <= COUNT_RESET;
    end
    else if (wr)
    begin
      if (adr_i == OFS_MODE_A && sel_i[0])
      begin
        mode_a_q <= dat_i[1:0];
      end
      if (adr_i == OFS_MODE_B && sel_i[0])
      begin
        mode_b_q <= dat_i[1:0];
      end
      if (adr_i == OFS_COUNT_A)
      begin
        load_a_q <= 16'(merge({16'h0, load_a_q}, dat_i, sel_i));
      end
      if (adr_i == OFS_COUNT_B)
      begin
        load_b_q <= 16'(merge({16'h0, load_b_q}, dat_i, sel_i));
      end
    end
  end

  // ----------------------------------------
  // Debug halt synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      halt_meta_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else
    begin
      halt_meta_q <= debug_halt_i;
      halt_q <= halt_meta_q;
    end
  end

  // ----------------------------------------
  // Timer halves
  // ----------------------------------------
  edge_detect u_edge_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_a_i),
    .edge_sel_i(ctl_q.edge_a),
    .hit_o(hit_a)
  );

  edge_detect u_edge_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_b_i),
    .edge_sel_i(ctl_q.edge_b),
    .hit_o(hit_b)
  );

  timer_half u_half_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i('{run: ctl_q.run_a, freeze: ctl_q.freeze_a, mode: mode_a_q, edge_sel: ctl_q.edge_a}),
    .halted_i(halt_q),
    .load_i(load_a_q),
    .edge_hit_i(hit_a),
    .state_o(st_a)
  );

  timer_half u_half_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i('{run: ctl_q.run_b, freeze: ctl_q.freeze_b, mode: mode_b_q, edge_sel: ctl_q.edge_b}),
    .halted_i(halt_q),
    .load_i(load_b_q),
    .edge_hit_i(hit_b),
    .state_o(st_b)
  );

  // ----------------------------------------
  // RTC counter
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rtc_q <= RTC_RESET;
    end
    else if (ctl_q.rtc_en)
    begin
      rtc_q <= rtc_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // PWM, ADC trigger and control outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_raw_q <= 1'b0;
    end
    else if (!ctl_q.run_a)
    begin
      pwm_raw_q <= 1'b0;
    end
    else if (st_a.timeout)
    begin
      pwm_raw_q <= ~pwm_raw_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_a_o <= 1'b0;
      adc_trigger_a_o <= 1'b0;
      control_o <= CONTROL_RESET;
    end
    else
    begin
      pwm_a_o <= pwm_raw_q ^ ctl_q.pwm_inv_a;
      adc_trigger_a_o <= st_a.timeout & ctl_q.adc_trig_a;
      control_o <= ctl_q;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_pwm_invert: assert property (@(posedge clk_i) disable iff (rst_i)
    pwm_a_o == ($past(pwm_raw_q) ^ $past(ctl_q.pwm_inv_a)))
    else $error("pwm output does not follow invert bit");
  a_trig_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    adc_trigger_a_o |-> $past(ctl_q.adc_trig_a) && $past(st_a.timeout))
    else $error("adc trigger without enable");
  a_rtc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(ctl_q.rtc_en) && !$past(rst_i) |-> $stable(rtc_q))
    else $error("rtc counted while disabled");
  a_rtc_step: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(ctl_q.rtc_en) && !$past(rst_i) |-> rtc_q == $past(rtc_q) + 32'h0000_0001)
    else $error("rtc did not count");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_q.rsvd7 == 1'b0)
    else $error("reserved bit set");
  a_ctl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == OFS_CONTROL && sel_i == 4'hf |=> ctl_q.run_a == $past(dat_i[B_RUN_A])
      && ctl_q.edge_b == $past(dat_i[B_EDGE_B_HI:B_EDGE_B_LO]))
    else $error("control write not stored");
  a_ctl_reset: assert property (@(posedge clk_i)
    rst_i |=> ctl_q == CONTROL_RESET)
    else $error("control not cleared by reset");
  a_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_q.run_a && ctl_q.freeze_a && halt_q ##1 ctl_q.run_a |-> $stable(st_a.count))
    else $error("timer a counted while frozen");
  a_freeze_b: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl_q.run_b && ctl_q.freeze_b && halt_q ##1 ctl_q.run_b |-> $stable(st_b.count))
    else $error("timer b counted while frozen");
  a_stop_b: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_q.run_b |=> !st_b.active)
    else $error("timer b active while disabled");
  a_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_q.run_a |=> !st_a.active)
    else $error("timer a active while disabled");
  a_edge_rsvd: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_q.edge_a == EDGE_RSVD |-> !hit_a) and (ctl_q.edge_b == EDGE_RSVD |-> !hit_b))
    else $error("reserved edge code produced a hit");
  a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held two cycles");
  c_trig: cover property (@(posedge clk_i) disable iff (rst_i) adc_trigger_a_o);
  c_freeze: cover property (@(posedge clk_i) disable iff (rst_i)
    halt_q && ctl_q.freeze_a && ctl_q.run_a);
  c_capture: cover property (@(posedge clk_i) disable iff (rst_i) st_b.capture);
endmodule
`default_nettype wire

// file: verification/cap_adc_partner.sv
// Far-side model: capture pin driver, PWM watcher and ADC trigger sink
`timescale 1ns/10ps
`default_nettype none
module cap_adc_partner (
  input wire logic clk_i,
  input wire logic pwm_i,
  input wire logic trig_i,
  output logic cap_a_o,
  output logic cap_b_o
);
  int trig_cnt = 0;
  int pwm_cnt = 0;
  logic pwm_q = 1'b0;
  logic adc_on = 1'b1;
  logic src_sel = 1'b1;
  initial
  begin
    cap_a_o = 1'b0;
    cap_b_o = 1'b0;
  end
  // ----------------------------------------
  // ADC side
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    pwm_q <= pwm_i;
    if (adc_on && src_sel && trig_i === 1'b1)
      trig_cnt <= trig_cnt + 1;
    if (pwm_q !== pwm_i)
      pwm_cnt <= pwm_cnt + 1;
  end
  // ----------------------------------------
  // Capture pins: one high pulse, idle low
  // ----------------------------------------
  task automatic pulse(input bit b, input int w);
    repeat (2)
    begin
      @(posedge clk_i);
      if (b)
        cap_b_o <= ~cap_b_o;
      else
        cap_a_o <= ~cap_a_o;
      repeat (w) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Testbench for the timer control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import timer_ctl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic halt = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rdat;
  logic ack;
  logic err;
  logic pwm;
  logic trig;
  logic [11:0] ctl;
  logic cap_a;
  logic cap_b;
  logic bus_err;
  logic [31:0] rv;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  timer_ctl u_timer_ctl (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
    .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
    .err_o(err), .debug_halt_i(halt), .capture_a_i(cap_a), .capture_b_i(cap_b),
    .pwm_a_o(pwm), .adc_trigger_a_o(trig), .control_o(ctl));
  cap_adc_partner u_cap_adc_partner (.clk_i(clk_i), .pwm_i(pwm), .trig_i(trig),
    .cap_a_o(cap_a), .cap_b_o(cap_b));

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task close_out;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    rv = rdat;
    bus_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    r = rv;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    logic [31:0] v;
    rd(OFS_CONTROL, v);
    chk("ctl reset", v, 32'h0000_0000);
    chk("ctl out reset", {pwm, trig, ctl}, 32'h0000_0000);
    for (int i = 0; i < 12; i++)
    begin
      wr(OFS_CONTROL, 32'h1 << i);
      rd(OFS_CONTROL, v);
      chk("ctl bit", v, (i == 7) ? 32'h0 : 32'h1 << i);
      chk("ctl pins", {20'h0, ctl}, (i == 7) ? 32'h0 : 32'h1 << i);
    end
    wr(OFS_CONTROL, 32'h0000_0fff);
    wb(1'b1, OFS_CONTROL, 32'h0000_0000, 4'h2);
    rd(OFS_CONTROL, v);
    chk("ctl byte lane", v, 32'h0000_007f);
    wr(OFS_CONTROL, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0fff, 4'hf);
    chk("unmapped err", bus_err, 32'h1);
    rd(OFS_CONTROL, v);
    chk("ctl after err", v, 32'h0000_0000);
    $display("test regs done");
  endtask
  task t_rtc;
    logic [31:0] a;
    logic [31:0] b;
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_CONTROL, (k == 1) ? 32'h10 : 32'h0);
      rd(OFS_RTC, a);
      rd(OFS_RTC, b);
      chk("rtc step", b - a, (k == 1) ? 32'h3 : 32'h0);
    end
    $display("test rtc done");
  endtask
  task t_trig;
    int t0;
    int p0;
    logic [31:0] v;
    wr(OFS_CONTROL, 32'h40);
    @(posedge clk_i);
    chk("pwm inverted idle", pwm, 32'h1);
    wr(OFS_CONTROL, 32'h0);
    @(posedge clk_i);
    chk("pwm idle", pwm, 32'h0);
    wr(OFS_MODE_A, MODE_ONESHOT);
    wr(OFS_COUNT_A, 32'h3);
    t0 = u_cap_adc_partner.trig_cnt;
    wr(OFS_CONTROL, 32'h21);
    repeat (30) @(posedge clk_i);
    chk("oneshot trig", u_cap_adc_partner.trig_cnt - t0, 32'h1);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_MODE_A, MODE_PERIODIC);
    t0 = u_cap_adc_partner.trig_cnt;
    p0 = u_cap_adc_partner.pwm_cnt;
    wr(OFS_CONTROL, 32'h1);
    repeat (40) @(posedge clk_i);
    chk("trig off", u_cap_adc_partner.trig_cnt - t0, 32'h0);
    chk("pwm toggles", u_cap_adc_partner.pwm_cnt - p0 >= 4, 32'h1);
    t0 = u_cap_adc_partner.trig_cnt;
    wr(OFS_CONTROL, 32'h21);
    repeat (40) @(posedge clk_i);
    chk("periodic trig", u_cap_adc_partner.trig_cnt - t0 >= 4, 32'h1);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_MODE_A, MODE_RSVD);
    t0 = u_cap_adc_partner.trig_cnt;
    wr(OFS_CONTROL, 32'h21);
    repeat (30) @(posedge clk_i);
    chk("idle mode trig", u_cap_adc_partner.trig_cnt - t0, 32'h0);
    rd(OFS_COUNT_A, v);
    chk("idle mode count", v, 32'h3);
    $display("test trigger done");
  endtask
  task t_freeze;
    logic [31:0] a1;
    logic [31:0] a2;
    logic [31:0] b1;
    logic [31:0] b2;
    logic f;
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_MODE_A, MODE_PERIODIC);
    wr(OFS_MODE_B, MODE_PERIODIC);
    wr(OFS_COUNT_A, 32'hffff);
    wr(OFS_COUNT_B, 32'hffff);
    for (int k = 0; k < 3; k++)
    begin
      f = (k != 1);
      halt <= (k != 2);
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CONTROL, 32'h101 | {f, 7'h0, f, 1'b0});
      repeat (5) @(posedge clk_i);
      rd(OFS_COUNT_A, a1);
      rd(OFS_COUNT_B, b1);
      rd(OFS_COUNT_A, a2);
      rd(OFS_COUNT_B, b2);
      chk("a step", a1 - a2, (k == 0) ? 32'h0 : 32'h6);
      chk("b step", b1 - b2, (k == 0) ? 32'h0 : 32'h6);
    end
    halt <= 1'b0;
    wr(OFS_CONTROL, 32'h0);
    rd(OFS_COUNT_A, a1);
    rd(OFS_COUNT_B, b1);
    chk("a stopped", a1, 32'hffff);
    chk("b stopped", b1, 32'hffff);
    $display("test freeze done");
  endtask
  task t_capture;
    logic [31:0] v;
    logic [7:0] mo;
    logic [7:0] co;
    for (int h = 0; h < 2; h++)
    begin
      mo = h ? OFS_MODE_B : OFS_MODE_A;
      co = h ? OFS_COUNT_B : OFS_COUNT_A;
      for (int c = 0; c < 4; c++)
      begin
        wr(OFS_CONTROL, 32'h0);
        wr(mo, MODE_CAPTURE);
        wr(co, 32'd100);
        wr(OFS_CONTROL, h ? (32'h100 | c << 10) : (32'h1 | c << 2));
        repeat (5) @(posedge clk_i);
        u_cap_adc_partner.pulse(h[0], 10);
        rd(co, v);
        chk("capture", v, 32'd100 - ((c == 3) ? 2 : (c == 2) ? 0 : 1));
      end
    end
    wr(OFS_CONTROL, 32'h0);
    $display("test capture done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_rtc();
    t_trig();
    t_freeze();
    t_capture();
    close_out();
  end
endmodule
`default_nettype wire
